// ==== rtl/pmcs_pkg.sv ====
// Shared constants, types and helpers for the power-mode clock selector
package pmcs_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SEC_TIMER_CONTROL = 8'h08;

   // Control register fields
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_SEL_HIGH_BIT = 1;
   localparam int CTRL_INT_FAST_BIT = 4;
   localparam int CTRL_CPU_GATE_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h10;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h93;

   // Status register fields
   localparam int STAT_SEC_BIT = 0;
   localparam int STAT_FAST_BIT = 2;
   localparam int STAT_PRI_BIT = 3;

   // Secondary timer control fields
   localparam int SEC_ENABLE_BIT = 3;
   localparam int SEC_ACTIVE_BIT = 6;
   localparam logic [7:0] SEC_CTRL_RESET = 8'h00;

   // ************************************************************
   // Bus answers and timing
   // ************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Two and a half cycles of a clock, rounded up to whole edges
   localparam int OLD_SYNC_TICKS = 3;
   localparam int NEW_SYNC_TICKS = 3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SRC_PRIMARY,
      SRC_SECONDARY,
      SRC_INTERNAL
   } pmcs_src_e;

   // Flag order: primary active, internal fast stable, secondary active
   typedef logic [2:0] pmcs_flags_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } pmcs_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pmcs_axi_rsp_s;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic pmcs_src_e decodeSource(input logic [1:0] sel);
      // High bit set selects internal block, low bit then ignored
      if (sel[1]) begin
         return SRC_INTERNAL;
      end
      return sel[0] ? SRC_SECONDARY : SRC_PRIMARY;
   endfunction : decodeSource

   function automatic pmcs_flags_t flagsFor(input pmcs_src_e src, input logic intFast,
                                            input logic primaryIsFast, input logic fastStable);
      pmcs_flags_t f;
      f = 3'b000;
      case (src)
         SRC_PRIMARY: f = {1'b1, primaryIsFast & fastStable, 1'b0};
         SRC_SECONDARY: f = 3'b001;
         SRC_INTERNAL: f = {1'b0, intFast & fastStable, 1'b0};
         default: f = 3'b000;
      endcase
      return f;
   endfunction : flagsFor

endpackage : pmcs_pkg

// ==== rtl/pmcs_power_mode_clock_select.sv ====
// Power-mode and system clock source controller with AXI4-Lite registers
//
// Behaviour
// - Gating bit decides CPU clocking; select field picks the system oscillator.
// - Select 00 primary, 01 secondary timer oscillator, 1x internal block.
// - Changing the select field switches source once new source runs.
// - Idle or Sleep entered only by halt; gating bit chooses which.
// - Halt with gating bit 0 stops CPU and peripheral clocks.
// - Halt with gating bit 1 keeps peripherals clocked, stops CPU.
// - Switch waits new start-up plus 2.5 old and 2.5 new cycles.
// - Three flags encode the current source: 100,010,001,110,000.
// - Reset starts in primary run unless two-speed start-up is on.
// - Primary run sets primary flag; fast flag if fast primary stable.
// - Secondary run: timer clock, primary off, secondary flag set, primary cleared.
// - Secondary entry deferred until its enable is set and oscillator ready.
// - Leaving secondary: keep timer clock until primary ready, then swap flags.
// - Secondary oscillator runs whenever its enable bit is set.
// - Internal selection covers fast, postscaled and slow internal oscillators.
// - Primary to internal switch shuts primary and clears its flag.
// - Sleep shuts the primary and internal oscillators and clears all status flags.
// - Wake-up leaves gating bit and select field unchanged.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pmcs_power_mode_clock_select #(
   parameter int OLD_TICKS = pmcs_pkg::OLD_SYNC_TICKS,
   parameter int NEW_TICKS = pmcs_pkg::NEW_SYNC_TICKS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register bus
   input wire pmcs_pkg::pmcs_axi_req_s axiReq,
   output pmcs_pkg::pmcs_axi_rsp_s axiRsp,
   // Core events
   input wire logic haltExec,
   input wire logic wakeEvent,
   // Configuration straps
   input wire logic twoSpeedStartup,
   input wire logic primaryIsFastInternal,
   // Oscillator status and edge ticks
   input wire logic primaryReady,
   input wire logic secondaryReady,
   input wire logic fastIntStable,
   input wire logic primaryTick,
   input wire logic secondaryTick,
   input wire logic internalTick,
   // Oscillator controls
   output logic primaryOscEnable,
   output logic internalOscEnable,
   output logic secondaryOscRun,
   // Clock tree controls
   output logic [1:0] sysClkSelect,
   output logic sysClkGate,
   output logic cpuClkEnable,
   output logic periphClkEnable
);

   initial begin
      if (OLD_TICKS < 1 || NEW_TICKS < 1) begin
         $error("pmcs_power_mode_clock_select: tick counts must be at least one");
      end
   end

   // ************************************************************
   // Declarations
   // ************************************************************
   typedef enum logic [2:0] {
      SW_RUN,
      SW_WAIT_READY,
      SW_OLD_SYNC,
      SW_NEW_SYNC,
      SW_SLEEP
   } pmcs_sw_e;

   pmcs_sw_e state_reg;
   pmcs_pkg::pmcs_src_e curSrc_reg;
   pmcs_pkg::pmcs_src_e tgtSrc_reg;
   pmcs_pkg::pmcs_src_e selSrc;
   pmcs_pkg::pmcs_flags_t flags_reg;
   logic [7:0] oscControl_reg;
   logic [7:0] secTimerControl_reg;
   logic idle_reg;
   logic fromSleep_reg;
   logic startup_reg;
   logic cntStart;
   logic cntTick;
   logic oldDone;
   logic newDone;
   logic tgtReady;
   logic awHeld_reg;
   logic wHeld_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;

   assign selSrc = pmcs_pkg::decodeSource(oscControl_reg[pmcs_pkg::CTRL_SEL_HIGH_BIT:
                                                         pmcs_pkg::CTRL_SEL_LSB]);

   function automatic logic srcReady(input pmcs_pkg::pmcs_src_e s);
      case (s)
         pmcs_pkg::SRC_PRIMARY: return primaryReady;
         // secondary needs its enable and a ready oscillator
         pmcs_pkg::SRC_SECONDARY:
            return secTimerControl_reg[pmcs_pkg::SEC_ENABLE_BIT] & secondaryReady;
         // internal block always available once requested
         pmcs_pkg::SRC_INTERNAL: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : srcReady

   function automatic logic srcTick(input pmcs_pkg::pmcs_src_e s);
      case (s)
         pmcs_pkg::SRC_PRIMARY: return primaryTick;
         pmcs_pkg::SRC_SECONDARY: return secondaryTick;
         pmcs_pkg::SRC_INTERNAL: return internalTick;
         default: return 1'b0;
      endcase
   endfunction : srcTick

   always_comb tgtReady = srcReady(tgtSrc_reg);

   // ************************************************************
   // Handover timing
   // ************************************************************
   // One counter serves both halves; they never overlap
   assign cntStart = (state_reg == SW_WAIT_READY && tgtReady) ||
                     (state_reg == SW_OLD_SYNC && oldDone);
   always_comb cntTick = (state_reg == SW_OLD_SYNC) ? srcTick(curSrc_reg) : srcTick(tgtSrc_reg);

   pmcs_tick_counter #(
      .TICKS(OLD_TICKS > NEW_TICKS ? OLD_TICKS : NEW_TICKS)
   ) u_sync_count (
      .mclk(mclk),
      .rst(rst),
      .start(cntStart),
      .tick(cntTick),
      .done(oldDone)
   );
   assign newDone = oldDone;

   // ************************************************************
   // Mode sequencer
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= SW_RUN;
         curSrc_reg <= pmcs_pkg::SRC_PRIMARY;
         tgtSrc_reg <= pmcs_pkg::SRC_PRIMARY;
         idle_reg <= 1'b0;
         fromSleep_reg <= 1'b0;
         startup_reg <= 1'b1;
      end else begin
         startup_reg <= 1'b0;
         case (state_reg)
            SW_RUN: begin
               if (startup_reg && twoSpeedStartup) begin
                  // run on internal block while primary starts
                  curSrc_reg <= pmcs_pkg::SRC_INTERNAL;
                  tgtSrc_reg <= pmcs_pkg::SRC_PRIMARY;
                  state_reg <= SW_WAIT_READY;
               end else if (idle_reg) begin
                  if (wakeEvent) begin
                     idle_reg <= 1'b0;
                  end
               end else if (haltExec) begin
                  // halt is the only entry to Idle or Sleep
                  if (oscControl_reg[pmcs_pkg::CTRL_CPU_GATE_BIT]) begin
                     idle_reg <= 1'b1;
                  end else begin
                     state_reg <= SW_SLEEP;
                  end
               end else if (selSrc != curSrc_reg) begin
                  tgtSrc_reg <= selSrc;
                  fromSleep_reg <= 1'b0;
                  state_reg <= SW_WAIT_READY;
               end
            end
            SW_WAIT_READY: begin
               // outside a wake from Sleep, the old clock keeps running while the new one starts
               if (tgtReady) begin
                  state_reg <= fromSleep_reg ? SW_NEW_SYNC : SW_OLD_SYNC;
               end
            end
            SW_OLD_SYNC: begin
               if (oldDone) begin
                  state_reg <= SW_NEW_SYNC;
               end
            end
            SW_NEW_SYNC: begin
               if (newDone && !cntStart) begin
                  curSrc_reg <= tgtSrc_reg;
                  fromSleep_reg <= 1'b0;
                  state_reg <= SW_RUN;
               end
            end
            SW_SLEEP: begin
               if (wakeEvent) begin
                  // resume on the source still selected
                  tgtSrc_reg <= selSrc;
                  fromSleep_reg <= 1'b1;
                  state_reg <= SW_WAIT_READY;
               end
            end
            default: state_reg <= SW_RUN;
         endcase
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_reg <= 3'b000;
      end else if (state_reg == SW_SLEEP || fromSleep_reg) begin
         // flags clear in Sleep until the wake handover ends
         flags_reg <= 3'b000;
      end else begin
         // flags follow only the settled source
         flags_reg <= pmcs_pkg::flagsFor(curSrc_reg,
                                         oscControl_reg[pmcs_pkg::CTRL_INT_FAST_BIT],
                                         primaryIsFastInternal, fastIntStable);
      end
   end

   // ************************************************************
   // Oscillator and clock tree controls
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         primaryOscEnable <= 1'b1;
         internalOscEnable <= 1'b1;
         secondaryOscRun <= 1'b0;
         sysClkSelect <= 2'h0;
         sysClkGate <= 1'b1;
         cpuClkEnable <= 1'b1;
         periphClkEnable <= 1'b1;
      end else begin
         // primary only runs while in use or being started
         primaryOscEnable <= (state_reg != SW_SLEEP) &&
                             ((curSrc_reg == pmcs_pkg::SRC_PRIMARY && !fromSleep_reg) ||
                              (tgtSrc_reg == pmcs_pkg::SRC_PRIMARY && state_reg != SW_RUN));
         internalOscEnable <= (state_reg != SW_SLEEP) &&
                              (curSrc_reg == pmcs_pkg::SRC_INTERNAL ||
                               tgtSrc_reg == pmcs_pkg::SRC_INTERNAL ||
                               primaryIsFastInternal);
         secondaryOscRun <= secTimerControl_reg[pmcs_pkg::SEC_ENABLE_BIT];
         sysClkSelect <= curSrc_reg;
         // low through the whole edge-synchronised handover
         sysClkGate <= !(state_reg == SW_OLD_SYNC || state_reg == SW_NEW_SYNC ||
                         state_reg == SW_SLEEP || (state_reg == SW_WAIT_READY &&
                         fromSleep_reg));
         cpuClkEnable <= state_reg != SW_SLEEP && !fromSleep_reg && !idle_reg;
         periphClkEnable <= state_reg != SW_SLEEP && !fromSleep_reg;
      end
   end

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         axiRsp.awready <= 1'b1;
         axiRsp.wready <= 1'b1;
         axiRsp.bvalid <= 1'b0;
         axiRsp.bresp <= pmcs_pkg::RESP_OKAY;
      end else begin
         if (axiReq.awvalid && axiRsp.awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= axiReq.awaddr;
            axiRsp.awready <= 1'b0;
         end
         if (axiReq.wvalid && axiRsp.wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= axiReq.wdata;
            wStrb_reg <= axiReq.wstrb;
            axiRsp.wready <= 1'b0;
         end
         if (awHeld_reg && wHeld_reg && !axiRsp.bvalid) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            axiRsp.bvalid <= 1'b1;
            case (awAddr_reg)
               pmcs_pkg::ADDR_OSC_CONTROL,
               pmcs_pkg::ADDR_CLOCK_STATUS,
               pmcs_pkg::ADDR_SEC_TIMER_CONTROL: axiRsp.bresp <= pmcs_pkg::RESP_OKAY;
               default: axiRsp.bresp <= pmcs_pkg::RESP_SLVERR;
            endcase
         end
         if (axiRsp.bvalid && axiReq.bready) begin
            axiRsp.bvalid <= 1'b0;
            axiRsp.awready <= 1'b1;
            axiRsp.wready <= 1'b1;
         end
      end
   end

   // Register stores; status is read-only
   always_ff @(posedge mclk) begin
      if (rst) begin
         oscControl_reg <= pmcs_pkg::CTRL_RESET;
         secTimerControl_reg <= pmcs_pkg::SEC_CTRL_RESET;
      end else if (awHeld_reg && wHeld_reg && !axiRsp.bvalid && wStrb_reg[0]) begin
         if (awAddr_reg == pmcs_pkg::ADDR_OSC_CONTROL) begin
            oscControl_reg <= wData_reg[7:0] & pmcs_pkg::CTRL_WRITE_MASK;
         end
         if (awAddr_reg == pmcs_pkg::ADDR_SEC_TIMER_CONTROL) begin
            secTimerControl_reg <= {4'h0, wData_reg[pmcs_pkg::SEC_ENABLE_BIT], 3'h0};
         end
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         axiRsp.arready <= 1'b1;
         axiRsp.rvalid <= 1'b0;
         axiRsp.rdata <= 32'h0000_0000;
         axiRsp.rresp <= pmcs_pkg::RESP_OKAY;
      end else if (axiReq.arvalid && axiRsp.arready) begin
         axiRsp.arready <= 1'b0;
         axiRsp.rvalid <= 1'b1;
         axiRsp.rresp <= pmcs_pkg::RESP_OKAY;
         axiRsp.rdata <= 32'h0000_0000;
         case (axiReq.araddr)
            pmcs_pkg::ADDR_OSC_CONTROL: axiRsp.rdata[7:0] <= oscControl_reg;
            pmcs_pkg::ADDR_CLOCK_STATUS: begin
               axiRsp.rdata[pmcs_pkg::STAT_PRI_BIT] <= flags_reg[2];
               axiRsp.rdata[pmcs_pkg::STAT_FAST_BIT] <= flags_reg[1];
               axiRsp.rdata[pmcs_pkg::STAT_SEC_BIT] <= flags_reg[0];
            end
            pmcs_pkg::ADDR_SEC_TIMER_CONTROL: begin
               axiRsp.rdata[7:0] <= secTimerControl_reg;
               axiRsp.rdata[pmcs_pkg::SEC_ACTIVE_BIT] <= flags_reg[0];
            end
            default: axiRsp.rresp <= pmcs_pkg::RESP_SLVERR;
         endcase
      end else if (axiRsp.rvalid && axiReq.rready) begin
         axiRsp.rvalid <= 1'b0;
         axiRsp.arready <= 1'b1;
      end
   end

endmodule : pmcs_power_mode_clock_select
`default_nettype wire

// ==== rtl/pmcs_tick_counter.sv ====
// Counts oscillator edge ticks after a start pulse
`timescale 1ns/1ps
`default_nettype none
module pmcs_tick_counter #(
   parameter int TICKS = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic tick,
   // Result
   output logic done
);

   localparam int CNT_W = $clog2(TICKS + 1);

   initial begin
      if (TICKS < 1 || TICKS > 255) begin
         $error("pmcs_tick_counter: TICKS out of range");
      end
   end

   logic [CNT_W-1:0] count_reg;
   logic running_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         count_reg <= '0;
         running_reg <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         count_reg <= '0;
         running_reg <= 1'b1;
         done <= 1'b0;
      end else if (running_reg && tick) begin
         if (count_reg == CNT_W'(TICKS - 1)) begin
            running_reg <= 1'b0;
            done <= 1'b1;
         end else begin
            count_reg <= count_reg + CNT_W'(1);
         end
      end else begin
         done <= 1'b0;
      end
   end

endmodule : pmcs_tick_counter
`default_nettype wire

// ==== testbench/pmcs_properties.sv ====
// Port-level temporal checks for the power-mode clock selector
`timescale 1ns/1ps
`default_nettype none
module pmcs_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register bus
   input wire pmcs_pkg::pmcs_axi_req_s axiReq,
   input wire pmcs_pkg::pmcs_axi_rsp_s axiRsp,
   // Core event and clock controls
   input wire logic haltExec,
   input wire logic primaryOscEnable,
   input wire logic [1:0] sysClkSelect,
   input wire logic sysClkGate,
   input wire logic cpuClkEnable,
   input wire logic periphClkEnable
);
   // ****************************************
   // Helper logic
   // ****************************************
   // Two-speed start may move the select right after reset without a handover
   logic [2:0] ageReg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ageReg <= 3'h0;
      end else if (ageReg != 3'h7) begin
         ageReg <= ageReg + 3'h1;
      end
   end

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence wrTaken;
      axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
   endsequence

   sequence rdDone;
      axiRsp.rvalid && axiReq.rready;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   chk_sleep_cpu_off: assert property (!periphClkEnable |-> !cpuClkEnable)
      else $error("peripheral clock stopped while cpu clocked");
   chk_halt_cause: assert property ($fell(cpuClkEnable) |->
      $past(haltExec) || $past(haltExec, 2) || $past(haltExec, 3))
      else $error("cpu clock stopped without halt");
   chk_handover_low: assert property ($fell(sysClkGate) |-> !sysClkGate [*3])
      else $error("clock gate reopened too soon");
   chk_switch_gated: assert property (ageReg == 3'h7 && $changed(sysClkSelect)
      |-> !$past(sysClkGate))
      else $error("source changed with clock passing");
   chk_primary_kept: assert property (sysClkSelect == 2'h0 && sysClkGate
      && periphClkEnable |-> primaryOscEnable)
      else $error("running from primary with primary stopped");
   chk_write_answer: assert property (wrTaken |-> ##[1:2] axiRsp.bvalid)
      else $error("write response missing");
   chk_write_refuse: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write taken while response pending");
   chk_write_release: assert property (axiRsp.bvalid && axiReq.bready
      |=> !axiRsp.bvalid && axiRsp.awready)
      else $error("write response not released");
   chk_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read data missing");
   chk_read_release: assert property (rdDone |=> !axiRsp.rvalid && axiRsp.arready)
      else $error("read data not released");
endmodule : pmcs_properties
`default_nettype wire

// ==== testbench/tb_power_mode_clock_select.sv ====
// Self-checking bench for the power-mode clock selector
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_clock_select;
   logic mclk, rst, haltExec, wakeEvent, twoSpeed, priReady, secReady, fastStable, priFast;
   logic priTick, secTick, intTick, priOscEn, intOscEn, secRun, gate, cpuEn, perEn;
   logic [1:0] clkSel, resp, sel;
   logic [31:0] rdat;
   pmcs_pkg::pmcs_axi_req_s axiReq;
   pmcs_pkg::pmcs_axi_rsp_s axiRsp;
   integer seed, err_total, num_checks, cycles, i;

   pmcs_power_mode_clock_select pmcs_power_mode_clock_select_i (.mclk(mclk), .rst(rst),
      .axiReq(axiReq), .axiRsp(axiRsp), .haltExec(haltExec), .wakeEvent(wakeEvent),
      .twoSpeedStartup(twoSpeed), .primaryIsFastInternal(priFast), .primaryReady(priReady),
      .secondaryReady(secReady), .fastIntStable(fastStable), .primaryTick(priTick),
      .secondaryTick(secTick), .internalTick(intTick), .primaryOscEnable(priOscEn),
      .internalOscEnable(intOscEn), .secondaryOscRun(secRun), .sysClkSelect(clkSel),
      .sysClkGate(gate), .cpuClkEnable(cpuEn), .periphClkEnable(perEn));

   // ****************************************
   // Clock, oscillator ticks, watchdog
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Irregular ticks stand in for oscillators unrelated to mclk
   always @(posedge mclk) begin
      {priTick, secTick, intTick} <= 3'($random(seed));
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // ****************************************
   // Bus and wait tasks
   // ****************************************
   task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge mclk);
      axiReq.awaddr <= a;
      axiReq.wdata <= {24'h00_0000, d};
      axiReq.wstrb <= 4'hf;
      {axiReq.awvalid, axiReq.wvalid, axiReq.bready} <= 3'h7;
      forever begin
         #1;
         ta = axiReq.awvalid & axiRsp.awready;
         tw = axiReq.wvalid & axiRsp.wready;
         tb = axiRsp.bvalid;
         r = axiRsp.bresp;
         @(posedge mclk);
         if (ta) axiReq.awvalid <= 1'b0;
         if (tw) axiReq.wvalid <= 1'b0;
         if (tb) begin
            axiReq.bready <= 1'b0;
            break;
         end
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge mclk);
      axiReq.araddr <= a;
      {axiReq.arvalid, axiReq.rready} <= 2'h3;
      forever begin
         #1;
         ta = axiReq.arvalid & axiRsp.arready;
         tr = axiRsp.rvalid;
         d = axiRsp.rdata;
         r = axiRsp.rresp;
         @(posedge mclk);
         if (ta) axiReq.arvalid <= 1'b0;
         if (tr) begin
            axiReq.rready <= 1'b0;
            break;
         end
      end
   endtask : axr

   task automatic stat(input logic [7:0] e);
      axr(pmcs_pkg::ADDR_CLOCK_STATUS, rdat, resp);
      chk("status", rdat, {24'h00_0000, e});
   endtask : stat

   task automatic waitFor(input logic [1:0] s);
      int n;
      n = 0;
      while ((clkSel !== s || gate !== 1'b1) && n < 300) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("clock select", 32'(clkSel), 32'(s));
      repeat (2) @(posedge mclk);
   endtask : waitFor

   task automatic pulse(input logic halt);
      if (halt) haltExec <= 1'b1;
      else wakeEvent <= 1'b1;
      @(posedge mclk);
      {haltExec, wakeEvent} <= 2'h0;
      repeat (40) @(posedge mclk);
   endtask : pulse

   function automatic logic [7:0] expStat(input logic [1:0] s, input logic fast);
      if (s[1]) return fast ? 8'h04 : 8'h00;
      return s[0] ? 8'h01 : 8'h08;
   endfunction : expStat

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 2351;
      {err_total, num_checks, cycles} = '0;
      {priTick, secTick, intTick, haltExec, wakeEvent, twoSpeed, priFast} = '0;
      {priReady, secReady, fastStable, rst} = 4'hf;
      axiReq = '0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      axr(pmcs_pkg::ADDR_OSC_CONTROL, rdat, resp);
      chk("control", rdat, {24'h00_0000, pmcs_pkg::CTRL_RESET});
      stat(8'h08);
      axr(8'h0c, rdat, resp);
      chk("unmapped", 32'(resp), 32'(pmcs_pkg::RESP_SLVERR));
      axw(pmcs_pkg::ADDR_CLOCK_STATUS, 8'hff, resp);
      stat(8'h08);
      // Timer oscillator off: selection must wait for its enable
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h11, resp);
      repeat (20) @(posedge mclk);
      stat(8'h08);
      axw(pmcs_pkg::ADDR_SEC_TIMER_CONTROL, 8'h08, resp);
      waitFor(2'h1);
      stat(8'h01);
      chk("primary osc", 32'(priOscEn), 32'h0);
      chk("timer osc", 32'(secRun), 32'h1);
      priReady <= 1'b0;
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h10, resp);
      repeat (15) @(posedge mclk);
      chk("held source", 32'(clkSel), 32'h1);
      chk("primary start", 32'(priOscEn), 32'h1);
      priReady <= 1'b1;
      waitFor(2'h0);
      stat(8'h08);
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h03, resp);
      waitFor(2'h2);
      stat(8'h00);
      chk("primary off", 32'(priOscEn), 32'h0);
      chk("internal osc", 32'(intOscEn), 32'h1);
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h10, resp);
      waitFor(2'h0);
      for (i = 0; i < 8; i++) begin
         sel = 2'($random(seed));
         axw(pmcs_pkg::ADDR_OSC_CONTROL, {6'h04, sel}, resp);
         waitFor(sel[1] ? 2'h2 : {1'b0, sel[0]});
         stat(expStat(sel, 1'b1));
      end
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h90, resp);
      waitFor(2'h0);
      pulse(1'b1);
      chk("idle cpu", 32'(cpuEn), 32'h0);
      chk("idle periph", 32'(perEn), 32'h1);
      stat(8'h08);
      pulse(1'b0);
      chk("idle wake", 32'(cpuEn), 32'h1);
      axr(pmcs_pkg::ADDR_OSC_CONTROL, rdat, resp);
      chk("control kept", rdat, 32'h0000_0090);
      axw(pmcs_pkg::ADDR_OSC_CONTROL, 8'h10, resp);
      pulse(1'b1);
      chk("sleep cpu", 32'(cpuEn), 32'h0);
      chk("sleep periph", 32'(perEn), 32'h0);
      chk("sleep osc", 32'(priOscEn), 32'h0);
      stat(8'h00);
      pulse(1'b0);
      chk("sleep wake", 32'(perEn), 32'h1);
      stat(8'h08);
      // Second reset with the fast start-up strap
      {twoSpeed, priFast, priReady, rst} <= 4'hd;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("two speed src", 32'(clkSel), 32'h2);
      stat(8'h04);
      priReady <= 1'b1;
      waitFor(2'h0);
      stat(8'h0c);
      test_done();
   end
endmodule : tb_power_mode_clock_select

bind pmcs_power_mode_clock_select pmcs_properties pmcs_properties_i (.mclk(mclk), .rst(rst),
   .axiReq(axiReq), .axiRsp(axiRsp), .haltExec(haltExec),
   .primaryOscEnable(primaryOscEnable), .sysClkSelect(sysClkSelect),
   .sysClkGate(sysClkGate), .cpuClkEnable(cpuClkEnable), .periphClkEnable(periphClkEnable));
`default_nettype wire
